// file: rsf_pkg.sv
// Purpose: Shared constants for the ramp status flag bank.
// Assumes: Register indices are word indices; byte address is four times the index.
// Notes:   Field positions refer to the 16 implemented status bits.
package rsf_pkg;
  // Register word indices
  localparam logic [7:0] IDX_STATUS     = 8'h2b;  // Motion ramp status
  localparam logic [7:0] IDX_IRQ_PEND   = 8'h30;  // Interrupt pending, read only
  localparam logic [7:0] IDX_IRQ_CLR    = 8'h31;  // Interrupt clear, write only
  localparam logic [7:0] IDX_IRQ_EN     = 8'h32;  // Interrupt enable
  localparam logic [7:0] IDX_WAIT_TIME  = 8'h33;  // Post halt wait time, in clocks
  localparam logic [7:0] IDX_CONTROL    = 8'h34;  // Control bits

  // Status field positions
  localparam int B_VIRT_R    = 15;
  localparam int B_VIRT_L    = 14;
  localparam int B_STALL     = 13;
  localparam int B_SECOND    = 12;
  localparam int B_WAIT      = 11;
  localparam int B_VZERO     = 10;
  localparam int B_POS_MATCH = 9;
  localparam int B_VEL_MATCH = 8;
  localparam int B_EV_POS    = 7;
  localparam int B_EV_SG     = 6;
  localparam int B_EV_STOP_R = 5;
  localparam int B_EV_STOP_L = 4;
  localparam int B_LATCH_R   = 3;
  localparam int B_LATCH_L   = 2;
  localparam int B_REF_R     = 1;
  localparam int B_REF_L     = 0;

  // Control field positions
  localparam int C_HALT_STALL = 0;

  // Bit groups of the status word
  localparam logic [15:0] LIVE_MASK   = 16'hef03;  // Levels sampled every cycle
  localparam logic [15:0] STICKY_MASK = 16'h10fc;  // Held until cleared
  localparam logic [15:0] W1C_MASK    = 16'h10cc;  // Software clearable

  // Reset values
  localparam logic [15:0] STATUS_RST  = 16'hc000;
  localparam logic [15:0] IRQ_EN_RST  = 16'h0000;
  localparam logic [15:0] WAIT_RST    = 16'h0000;
  localparam logic [31:0] CONTROL_RST = 32'h0000_0000;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : rsf_pkg

// file: rsf_top.sv
// Purpose: Ramp status flag bank with AXI4-Lite access and one interrupt line.
// Assumes: All motion inputs come from logic on CLK; no synchronisers needed.
// Notes:   Live bits show the input level one clock late.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module rsf_top
  import rsf_pkg::*;
#(
  parameter int ADDR_W = 12,  // AXI address width
  parameter int POS_W  = 32,  // Position width
  parameter int VEL_W  = 32,  // Velocity width
  parameter int WAIT_W = 16   // Wait counter width
) (
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              RESET,
  input  wire logic              CE,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  // AXI4-Lite write data
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  // AXI4-Lite read data
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  // Ramp generator state
  input  wire logic [POS_W-1:0]  CURRENT_POSITION,
  input  wire logic [POS_W-1:0]  GOAL_POSITION,
  input  wire logic [VEL_W-1:0]  CURRENT_VELOCITY,
  input  wire logic [VEL_W-1:0]  PEAK_VELOCITY_SETTING,
  input  wire logic              REVERSE_MOVE,
  input  wire logic              HOLD_MODE,
  input  wire logic              MOVE_LEFT_CMD,
  input  wire logic              MOVE_RIGHT_CMD,
  // Limit, switch and stall sources
  input  wire logic              VIRT_STOP_R,
  input  wire logic              VIRT_STOP_L,
  input  wire logic              STOP_R_ACTIVE,
  input  wire logic              STOP_L_ACTIVE,
  input  wire logic              REF_R,
  input  wire logic              REF_L,
  input  wire logic              LATCH_R_DONE,
  input  wire logic              LATCH_L_DONE,
  input  wire logic              LOAD_STALL_LIVE,
  // Outputs to the motion logic
  output logic                   STEP_INHIBIT,
  output logic                   HALT_ON_LOAD_STALL,
  output logic                   IRQ
);

  // Word index of a byte address
  function automatic logic [7:0] word_idx(input logic [ADDR_W-1:0] a);
    word_idx = a[9:2];
  endfunction

  // Byte strobes widened to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // Bus state
  logic              awready_q;   // Address slot free
  logic              wready_q;    // Data slot free
  logic              aw_held_q;   // Address captured
  logic              w_held_q;    // Data captured
  logic [ADDR_W-1:0] awaddr_q;    // Captured write address
  logic [31:0]       wdata_q;     // Captured data, strobes applied
  logic              bvalid_q;    // Write answer pending
  logic [1:0]        bresp_q;     // Write answer code
  logic              arready_q;   // Read slot free
  logic              rvalid_q;    // Read answer pending
  logic [31:0]       rdata_q;     // Read answer data
  logic [1:0]        rresp_q;     // Read answer code
  // Register state
  logic [15:0]       stat_q;      // Status word
  logic [15:0]       stat_d;
  logic [15:0]       irq_pend_q;  // Interrupt pending
  logic [15:0]       irq_pend_d;
  logic [15:0]       irq_en_q;    // Interrupt enable
  logic [WAIT_W-1:0] wait_time_q; // Wait length in clocks
  logic [WAIT_W-1:0] wait_cnt_q;  // Remaining wait
  logic              wait_act_q;  // Wait running
  logic              halt_sg_q;   // Stall halt enable
  logic              irq_q;       // Interrupt line
  // Decoded strobes
  logic              do_wr;       // One cycle write commit
  logic [7:0]        wr_idx;
  logic [15:0]       set_vec;     // Hardware set events
  logic [15:0]       hclr_vec;    // Hardware clears
  logic [15:0]       swclr_vec;   // Software clears
  logic [15:0]       live_vec;    // Live levels
  logic              vzero_now;
  logic              wr_known;

  // Commit once both halves are held and no answer is pending
  assign do_wr  = aw_held_q && w_held_q && !bvalid_q;
  assign wr_idx = word_idx(awaddr_q);
  assign wr_known = (wr_idx == IDX_STATUS) || (wr_idx == IDX_IRQ_CLR) ||
                    (wr_idx == IDX_IRQ_EN) || (wr_idx == IDX_WAIT_TIME) ||
                    (wr_idx == IDX_CONTROL) || (wr_idx == IDX_IRQ_PEND);

  // Write channels, address and data taken in either order
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else if (CE) begin
      // Capture address
      if (S_AXI_AWVALID && awready_q) begin
        awaddr_q  <= S_AXI_AWADDR;
        aw_held_q <= 1'b1;
        awready_q <= 1'b0;
      end
      // Capture data; masked lanes count as zero, so they clear no flag but zero their enable, wait or control bits
      if (S_AXI_WVALID && wready_q) begin
        wdata_q  <= S_AXI_WDATA & strb_mask(S_AXI_WSTRB);
        w_held_q <= 1'b1;
        wready_q <= 1'b0;
      end
      // Commit and answer
      if (do_wr) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      // Answer taken, reopen both slots
      if (bvalid_q && S_AXI_BREADY) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // Read channel, answer one clock after the address
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else if (CE) begin
      if (S_AXI_ARVALID && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rresp_q   <= RESP_OKAY;
        case (word_idx(S_AXI_ARADDR))
          IDX_STATUS:    rdata_q <= {16'h0000, stat_q};
          IDX_IRQ_PEND:  rdata_q <= {16'h0000, irq_pend_q};
          IDX_IRQ_EN:    rdata_q <= {16'h0000, irq_en_q};
          IDX_WAIT_TIME: rdata_q <= {{(32-WAIT_W){1'b0}}, wait_time_q};
          IDX_CONTROL:   rdata_q <= {31'h0000_0000, halt_sg_q};
          IDX_IRQ_CLR:   rdata_q <= 32'h0000_0000;
          default: begin
            // Unmapped word
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_SLVERR;
          end
        endcase
      end
      if (rvalid_q && S_AXI_RREADY) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      irq_en_q    <= IRQ_EN_RST;
      wait_time_q <= WAIT_RST[WAIT_W-1:0];
      halt_sg_q   <= CONTROL_RST[C_HALT_STALL];
    end else if (CE && do_wr) begin
      if (wr_idx == IDX_IRQ_EN)    irq_en_q    <= wdata_q[15:0] & STICKY_MASK;
      if (wr_idx == IDX_WAIT_TIME) wait_time_q <= wdata_q[WAIT_W-1:0];
      if (wr_idx == IDX_CONTROL)   halt_sg_q   <= wdata_q[C_HALT_STALL];
    end
  end

  // Post halt wait starts when velocity reaches zero
  assign vzero_now = (CURRENT_VELOCITY == '0);
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      wait_cnt_q <= '0;
      wait_act_q <= 1'b0;
    end else if (CE) begin
      if (vzero_now && !stat_q[B_VZERO] && (wait_time_q != '0)) begin
        wait_cnt_q <= wait_time_q;
        wait_act_q <= 1'b1;
      end else if (wait_cnt_q > 1) begin
        wait_cnt_q <= wait_cnt_q - 1'b1;
      end else begin
        wait_cnt_q <= '0;
        wait_act_q <= 1'b0;
      end
    end
  end

  // Event, clear and level vectors in status layout
  always_comb begin
    set_vec = '0;
    set_vec[B_SECOND]    = REVERSE_MOVE;
    set_vec[B_EV_POS]    = (CURRENT_POSITION == GOAL_POSITION) && !stat_q[B_POS_MATCH];
    set_vec[B_EV_SG]     = LOAD_STALL_LIVE && halt_sg_q;
    set_vec[B_EV_STOP_R] = STOP_R_ACTIVE;
    set_vec[B_EV_STOP_L] = STOP_L_ACTIVE;
    set_vec[B_LATCH_R]   = LATCH_R_DONE;
    set_vec[B_LATCH_L]   = LATCH_L_DONE;
    hclr_vec = '0;
    hclr_vec[B_EV_STOP_R] = HOLD_MODE || MOVE_LEFT_CMD;
    hclr_vec[B_EV_STOP_L] = HOLD_MODE || MOVE_RIGHT_CMD;
    // Only ones in clearable positions act; all else ignored
    swclr_vec = (do_wr && wr_idx == IDX_STATUS) ? (wdata_q[15:0] & W1C_MASK) : 16'h0000;
    live_vec = '0;
    live_vec[B_VIRT_R]    = VIRT_STOP_R;
    live_vec[B_VIRT_L]    = VIRT_STOP_L;
    live_vec[B_STALL]     = LOAD_STALL_LIVE;
    live_vec[B_WAIT]      = wait_act_q;
    live_vec[B_VZERO]     = vzero_now;
    live_vec[B_POS_MATCH] = (CURRENT_POSITION == GOAL_POSITION);
    live_vec[B_VEL_MATCH] = (CURRENT_VELOCITY == PEAK_VELOCITY_SETTING);
    live_vec[B_REF_R]     = REF_R;
    live_vec[B_REF_L]     = REF_L;
    // A set in the clearing cycle wins
    stat_d = (live_vec & LIVE_MASK) |
             (((stat_q & ~swclr_vec & ~hclr_vec) | set_vec) & STICKY_MASK);
    irq_pend_d = (irq_pend_q & ~((do_wr && wr_idx == IDX_IRQ_CLR) ?
                  wdata_q[15:0] : 16'h0000)) | (set_vec & STICKY_MASK);
  end

  // Status and interrupt state
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      stat_q     <= STATUS_RST;
      irq_pend_q <= '0;
      irq_q      <= 1'b0;
    end else if (CE) begin
      stat_q     <= stat_d;
      irq_pend_q <= irq_pend_d;
      irq_q      <= |(irq_pend_d & irq_en_q);
    end
  end

  // Outputs straight from flops
  assign S_AXI_AWREADY      = awready_q;
  assign S_AXI_WREADY       = wready_q;
  assign S_AXI_BVALID       = bvalid_q;
  assign S_AXI_BRESP        = bresp_q;
  assign S_AXI_ARREADY      = arready_q;
  assign S_AXI_RVALID       = rvalid_q;
  assign S_AXI_RDATA        = rdata_q;
  assign S_AXI_RRESP        = rresp_q;
  assign STEP_INHIBIT       = wait_act_q;
  assign HALT_ON_LOAD_STALL = halt_sg_q;
  assign IRQ                = irq_q;

  // Checks
  virt_right_a: assert property (@(posedge CLK) disable iff (RESET)
    CE |=> stat_q[B_VIRT_R] == $past(VIRT_STOP_R)) else $error("right limit bit wrong");
  virt_left_a: assert property (@(posedge CLK) disable iff (RESET)
    CE |=> stat_q[B_VIRT_L] == $past(VIRT_STOP_L)) else $error("left limit bit wrong");
  stall_live_a: assert property (@(posedge CLK) disable iff (RESET)
    CE ##1 CE |=> stat_q[B_STALL] == $past(LOAD_STALL_LIVE)) else $error("stall bit wrong");
  second_move_a: assert property (@(posedge CLK) disable iff (RESET)
    CE && REVERSE_MOVE |=> stat_q[B_SECOND]) else $error("reversal not latched");
  wait_start_a: assert property (@(posedge CLK) disable iff (RESET)
    CE && vzero_now && !stat_q[B_VZERO] && wait_time_q != '0 |=> ##1 stat_q[B_WAIT] || !$past(CE))
    else $error("wait bit not raised");
  wait_inhibit_a: assert property (@(posedge CLK) disable iff (RESET)
    CE && vzero_now && !stat_q[B_VZERO] && wait_time_q != '0 |=> STEP_INHIBIT)
    else $error("steps allowed during wait");
  vzero_bit_a: assert property (@(posedge CLK) disable iff (RESET)
    CE |=> stat_q[B_VZERO] == $past(CURRENT_VELOCITY == '0)) else $error("vzero bit wrong");
  pos_match_a: assert property (@(posedge CLK) disable iff (RESET)
    CE |=> stat_q[B_POS_MATCH] == $past(CURRENT_POSITION == GOAL_POSITION))
    else $error("position match wrong");
  vel_match_a: assert property (@(posedge CLK) disable iff (RESET)
    CE |=> stat_q[B_VEL_MATCH] == $past(CURRENT_VELOCITY == PEAK_VELOCITY_SETTING))
    else $error("velocity match wrong");
  pos_event_a: assert property (@(posedge CLK) disable iff (RESET)
    CE && set_vec[B_EV_POS] |=> stat_q[B_EV_POS]) else $error("goal event lost");
  stop_clear_a: assert property (@(posedge CLK) disable iff (RESET)
    CE && HOLD_MODE && !STOP_R_ACTIVE |=> !stat_q[B_EV_STOP_R]) else $error("stop not cleared");
  latch_hold_a: assert property (@(posedge CLK) disable iff (RESET)
    CE && stat_q[B_LATCH_R] && !swclr_vec[B_LATCH_R] |=> stat_q[B_LATCH_R])
    else $error("capture flag dropped");
  upper_zero_a: assert property (@(posedge CLK) disable iff (RESET)
    CE && S_AXI_ARVALID && arready_q && word_idx(S_AXI_ARADDR) == IDX_STATUS
    |=> rdata_q[31:16] == 16'h0000) else $error("upper status bits set");
  w1c_keep_a: assert property (@(posedge CLK) disable iff (RESET)
    CE && stat_q[B_EV_POS] && !(do_wr && wr_idx == IDX_STATUS && wdata_q[B_EV_POS])
    |=> stat_q[B_EV_POS]) else $error("flag lost without clear");
  cover_write_c: cover property (@(posedge CLK) disable iff (RESET) do_wr && wr_idx == IDX_STATUS);
  cover_irq_c:   cover property (@(posedge CLK) disable iff (RESET) $rose(irq_q));
  cover_wait_c:  cover property (@(posedge CLK) disable iff (RESET) $fell(wait_act_q));
  cover_read_c:  cover property (@(posedge CLK) disable iff (RESET) rvalid_q && S_AXI_RREADY);

endmodule // rsf_top

// file: test_ramp_status_flags.sv
// Purpose: Self-checking bench for the ramp status flag bank over AXI4-Lite.
// Assumes: Full write strobes, so every bus word lands whole; CE drops once, bus idle.
// Notes:   Drivers queue expected answers; a monitor compares them as they arrive.
`timescale 1ns/1ps
module test_ramp_status_flags;
  import rsf_pkg::*;
  // Clock, reset and bus
  logic        clk, reset, ce;
  logic [11:0] awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, rdata;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  // Motion side
  logic [31:0] cur_pos, goal_pos, cur_vel, peak_vel;
  logic [7:0]  ev;        // Strobes: rev, hold, mv_l, mv_r, stop_r, stop_l, cap_r, cap_l
  logic [4:0]  lv;        // Levels: virt r, virt l, stall, ref r, ref l
  logic        step_inh, halt_stall, irq;
  // Scoreboard
  logic [34:0] rq[$];     // Read notes: irq, resp, data
  logic [1:0]  bq[$];     // Write response notes
  int          n_errors, checks_done, cycles, hi;
  logic [31:0] seed;

  rsf_top u_rsf_top (
    .CLK(clk), .RESET(reset), .CE(ce),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .CURRENT_POSITION(cur_pos), .GOAL_POSITION(goal_pos), .CURRENT_VELOCITY(cur_vel),
    .PEAK_VELOCITY_SETTING(peak_vel), .REVERSE_MOVE(ev[0]), .HOLD_MODE(ev[1]),
    .MOVE_LEFT_CMD(ev[2]), .MOVE_RIGHT_CMD(ev[3]), .VIRT_STOP_R(lv[4]), .VIRT_STOP_L(lv[3]),
    .STOP_R_ACTIVE(ev[4]), .STOP_L_ACTIVE(ev[5]), .REF_R(lv[1]), .REF_L(lv[0]),
    .LATCH_R_DONE(ev[6]), .LATCH_L_DONE(ev[7]), .LOAD_STALL_LIVE(lv[2]),
    .STEP_INHIBIT(step_inh), .HALT_ON_LOAD_STALL(halt_stall), .IRQ(irq)
  );

  // Free-running 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Pseudo-random source, fixed start
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  // Case-equal compare; an unknown bit matches only an unknown bit
  task automatic check(input string what, input logic [34:0] seen, input logic [34:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic test_done;
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Write one word; address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] idx, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    bq.push_back(r);
    @(posedge clk);
    awaddr  <= {2'b00, idx, 2'b00};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (awvalid && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge clk);
    bready <= 1'b0;
  endtask

  // Read one word; the monitor judges the answer
  task automatic rd(input logic [7:0] idx, input logic [31:0] d, input logic irq_e = 1'b0,
                    input logic [1:0] resp_e = RESP_OKAY);
    rq.push_back({irq_e, resp_e, d});
    @(posedge clk);
    araddr  <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk);
    rready <= 1'b0;
  endtask

  // One-cycle event strobes, then time for sticky bits to land
  task automatic pulse(input logic [7:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 8'h00;
    repeat (2) @(posedge clk);
  endtask

  // Monitor: oldest note against each answer
  always @(posedge clk) begin
    if (!reset && rvalid && rready) begin
      check("read", {irq, rresp, rdata}, rq.pop_front());
    end
    if (!reset && bvalid && bready) begin
      check("bresp", {33'h0, bresp}, {33'h0, bq.pop_front()});
    end
  end

  // Hang guard; the run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_errors++;
      test_done();
    end
  end

  // Main sequence
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {ev, lv} = {8'h00, 5'b11000};
    {cur_pos, goal_pos, cur_vel, peak_vel} = {32'h1, 32'h2, 32'h5, 32'h9};
    {n_errors, checks_done, cycles, hi} = '0;
    seed = 32'h4c214125;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    // Reset values of every register
    rd(IDX_STATUS, {16'h0, STATUS_RST});
    rd(IDX_IRQ_EN, {16'h0, IRQ_EN_RST});
    rd(IDX_WAIT_TIME, {16'h0, WAIT_RST});
    rd(IDX_CONTROL, CONTROL_RST);
    rd(IDX_IRQ_PEND, 32'h0);
    rd(IDX_IRQ_CLR, 32'h0);
    // Random live levels with goal reached and peak speed held
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      @(posedge clk);
      lv <= seed[4:0];
      {cur_pos, goal_pos} <= {seed, seed};
      {cur_vel, peak_vel} <= {seed[31:8], 8'h01, seed[31:8], 8'h01};
      repeat (2) @(posedge clk);
      rd(IDX_STATUS, {16'h0, seed[4:2], 5'b00011, 1'b1, 5'b0, seed[1:0]});
    end
    lv <= 5'b0;
    // Sticky flags: zero write keeps them, ones clear them
    pulse(8'hc1);
    wr(IDX_STATUS, 32'h0);
    rd(IDX_STATUS, 32'h0000138c);
    wr(IDX_STATUS, 32'hffffffff);
    rd(IDX_STATUS, 32'h00000300);
    // Stop events ignore writes, clear on opposite move or hold
    pulse(8'h30);
    wr(IDX_STATUS, 32'h30);
    rd(IDX_STATUS, 32'h00000330);
    pulse(8'h04);
    rd(IDX_STATUS, 32'h00000310);
    pulse(8'h08);
    rd(IDX_STATUS, 32'h00000300);
    pulse(8'h30);
    pulse(8'h02);
    rd(IDX_STATUS, 32'h00000300);
    // Interrupt: raise, mask, clear
    wr(IDX_IRQ_CLR, 32'h0000ffff);
    rd(IDX_IRQ_PEND, 32'h0);
    wr(IDX_IRQ_EN, 32'h00001000);
    rd(IDX_IRQ_EN, 32'h00001000);
    pulse(8'h01);
    rd(IDX_IRQ_PEND, 32'h00001000, 1'b1);
    wr(IDX_IRQ_PEND, 32'h0);
    wr(IDX_IRQ_EN, 32'h0);
    rd(IDX_IRQ_PEND, 32'h00001000, 1'b0);
    wr(IDX_IRQ_EN, 32'h00001000);
    wr(IDX_IRQ_CLR, 32'h00001000);
    rd(IDX_IRQ_PEND, 32'h0);
    rd(IDX_STATUS, 32'h00001300);
    wr(IDX_STATUS, 32'h00001000);
    // Post-halt wait: length of step inhibit, then flag mid-wait
    wr(IDX_WAIT_TIME, 32'h00000028);
    rd(IDX_WAIT_TIME, 32'h00000028);
    cur_vel <= 32'h0;
    for (int i = 0; i < 60; i++) begin
      @(posedge clk);
      if (step_inh === 1'b1) hi++;
    end
    check("inhibit cycles", 35'(hi), 35'h28);
    rd(IDX_STATUS, 32'h00000600);
    cur_vel <= 32'h7;
    repeat (2) @(posedge clk);
    cur_vel <= 32'h0;
    repeat (3) @(posedge clk);
    rd(IDX_STATUS, 32'h00000e00);
    repeat (60) @(posedge clk);
    rd(IDX_STATUS, 32'h00000600);
    // Stall halt enabled: a short stall is caught though the live bit drops
    wr(IDX_CONTROL, 32'h1);
    @(posedge clk);
    check("halt on stall", {34'h0, halt_stall}, 35'h1);
    rd(IDX_CONTROL, 32'h1);
    lv <= 5'b00100;
    @(posedge clk);
    lv <= 5'b0;
    repeat (2) @(posedge clk);
    rd(IDX_STATUS, 32'h00000640);
    wr(IDX_STATUS, 32'h40);
    rd(IDX_STATUS, 32'h00000600);
    // Clock enable low: a reversal strobe must leave no trace
    ce <= 1'b0;
    pulse(8'h01);
    ce <= 1'b1;
    rd(IDX_STATUS, 32'h00000600);
    // Unmapped place refuses both ways
    rd(8'h3f, 32'h0, 1'b0, RESP_SLVERR);
    wr(8'h3f, 32'hffffffff, RESP_SLVERR);
    rd(IDX_STATUS, 32'h00000600);
    repeat (5) @(posedge clk);
    check("notes left", 35'(rq.size() + bq.size()), 35'h0);
    test_done();
  end
endmodule // test_ramp_status_flags
